/* File: rtl/dcma_pkg.sv */
// Package: profile, strobe and address constants for the daughtercard memory port adapter
package dcma_pkg;
  typedef enum logic [1:0] {
    DCMA_PROF_A = 2'h0,
    DCMA_PROF_B = 2'h1,
    DCMA_PROF_C = 2'h2,
    DCMA_PROF_D = 2'h3
  } dcma_prof_t;

  typedef enum logic [1:0] {
    DCMA_SP_DATA = 2'h0,
    DCMA_SP_PROG = 2'h1,
    DCMA_SP_IO   = 2'h2
  } dcma_space_t;

  localparam int         DCMA_ADDR_W       = 20;
  localparam int         DCMA_DATA_W       = 32;
  localparam int         DCMA_NSEL         = 4;
  localparam logic [19:0] DCMA_A_PRIM_TOP  = 20'hE_FFFF;
  localparam logic [19:0] DCMA_FULL_TOP    = 20'hF_FFFF;
  localparam logic [19:0] DCMA_PROG_BASE   = 20'h8_0000;
  localparam logic [19:0] DCMA_D_TOP       = 20'h0_000F;
  localparam logic [3:0]  DCMA_BE_ALL      = 4'hF;
  localparam logic [31:0] DCMA_DATA_RST    = 32'h0000_0000;
  localparam logic [19:0] DCMA_ADDR_RST    = 20'h0_0000;
  localparam int         DCMA_WAIT_CYC     = 2;
  localparam int         DCMA_TMR_DIV_RST  = 4;
endpackage

/* File: rtl/dcma_if.sv */
// Interface: memory port pins between motherboard controller and card adapter
`timescale 1ns/1ps
`default_nettype none
interface dcma_if;
  logic [19:0] addr;
  logic [1:0]  half_hi;
  logic [3:0]  be_n;
  logic [3:0]  sel_n;
  logic        oe_n;
  logic        re_n;
  logic        we_n;
  logic        iostrb_n;
  logic        mstrb_n;
  logic        ready;
  logic [31:0] mb_dout;
  logic        mb_doe;
  logic [31:0] card_dout;
  logic        card_doe;
  logic [31:0] data;
  assign data = card_doe ? card_dout : (mb_doe ? mb_dout : 32'h0000_0000);

  modport motherboard (
    output addr, half_hi, be_n, sel_n, oe_n, re_n, we_n, iostrb_n, mstrb_n,
    output mb_dout, mb_doe,
    input  ready, data
  );
  modport card (
    input  addr, half_hi, be_n, sel_n, oe_n, re_n, we_n, iostrb_n, mstrb_n,
    input  data,
    output card_dout, card_doe, ready
  );
endinterface
`default_nettype wire

/* File: rtl/dcma_card.sv */
// Card end: decodes selects and strobes by profile, serves a small word memory
`timescale 1ns/1ps
`default_nettype none
module dcma_card
  import dcma_pkg::*;
#(
  parameter int MEM_WORDS = 64
) (
  input  wire logic              I_CORE_CLK,   // Core clock
  input  wire logic              I_RST_N,      // Sync reset, active low
  input  wire dcma_pkg::dcma_prof_t I_PROFILE, // Static board profile
  input  wire logic              I_BIG_ENDIAN, // Motherboard endianness (profile B)
  input  wire logic [1:0]        I_NARROW,     // 0:32 1:16 2:8 bit card memory
  input  wire logic              I_TMR_IN,     // Timer input pin
  output logic                   O_TMR_EVENT,  // One pulse per timer input edge
  output logic                   O_TMR_GPI,    // Timer input as GPIO level
  output logic                   O_HIT,        // Access decoded to card
  output logic [19:0]            O_WADDR,      // Decoded word index
  dcma_if.card                   bus           // Memory port
);
  import dcma_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_DONE = 2'b11
  } dcma_st_t;

  logic [31:0] mem [MEM_WORDS];
  dcma_st_t    st_r, st_nxt;
  logic [1:0]  wcnt_r, wcnt_nxt;
  logic [31:0] dout_r, dout_nxt;
  logic        doe_r, doe_nxt;
  logic        hit_r, hit_nxt;
  logic [19:0] wa_r, wa_nxt;
  logic [2:0]  tin_sync_r;
  logic        tin_lvl_r;
  logic        hit;
  logic        rd;
  logic        wr;
  logic [19:0] widx;
  logic [1:0]  lsh;
  logic [31:0] wd_sh;
  logic [3:0]  be_sh;

  function automatic logic [31:0] lane_place(input logic [31:0] d, input logic [1:0] nar, input logic hi);
    logic [31:0] r;
    r = d;
    if (nar == 2'd1) begin
      r = hi ? {d[15:0], 16'h0000} : {16'h0000, d[15:0]};
    end else if (nar == 2'd2) begin
      r = hi ? {d[7:0], 24'h00_0000} : {24'h00_0000, d[7:0]};
    end
    return r;
  endfunction

  always_comb begin
    hit  = 1'b0;
    widx = bus.addr;
    case (I_PROFILE)
      DCMA_PROF_A: begin
        hit = (!bus.sel_n[0] && bus.addr <= DCMA_A_PRIM_TOP) || !bus.sel_n[1] || !bus.sel_n[2];
      end
      DCMA_PROF_B: begin
        hit = !bus.sel_n[1] || !bus.sel_n[2];
      end
      DCMA_PROF_C: begin
        hit = (!bus.sel_n[DCMA_SP_DATA] && !bus.mstrb_n) ||
              (!bus.sel_n[DCMA_SP_PROG] && !bus.mstrb_n && bus.addr >= DCMA_PROG_BASE) ||
              (!bus.sel_n[DCMA_SP_IO] && !bus.iostrb_n);
      end
      DCMA_PROF_D: begin
        hit = (bus.sel_n != 4'hF) && bus.addr <= DCMA_D_TOP;
      end
      default: hit = 1'b0;
    endcase
  end

  assign rd = hit && !bus.oe_n && !bus.re_n;
  assign wr = hit && !bus.we_n;

  // Big-endian narrow memory sits on the high lanes; shift them down so the
  // array always holds narrow data in its low bits, as lane_place expects
  always_comb begin
    lsh = 2'd0;
    if ((I_PROFILE == DCMA_PROF_B) && I_BIG_ENDIAN) begin
      if (I_NARROW == 2'd1) begin
        lsh = 2'd2;
      end else if (I_NARROW == 2'd2) begin
        lsh = 2'd3;
      end
    end
  end

  assign wd_sh = bus.data >> {lsh, 3'b000};
  assign be_sh = 4'({4'hF, bus.be_n} >> lsh);

  always_comb begin
    st_nxt   = st_r;
    wcnt_nxt = wcnt_r;
    dout_nxt = dout_r;
    doe_nxt  = rd;
    hit_nxt  = hit;
    wa_nxt   = widx;
    case (st_r)
      ST_IDLE: begin
        if (rd || wr) begin
          st_nxt   = ST_WAIT;
          wcnt_nxt = 2'(DCMA_WAIT_CYC);
        end
      end
      ST_WAIT: begin
        if (wcnt_r == 2'd0) begin
          st_nxt = ST_DONE;
          if (rd) begin
            // Narrow ROM in profile A is always low lanes; B follows endianness
            dout_nxt = lane_place(mem[widx[5:0]], I_NARROW,
                                  (I_PROFILE == DCMA_PROF_B) && I_BIG_ENDIAN);
          end
        end else begin
          wcnt_nxt = wcnt_r - 2'd1;
        end
      end
      ST_DONE: begin
        if (!rd && !wr) begin
          st_nxt = ST_IDLE;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      st_r   <= ST_IDLE;
      wcnt_r <= 2'd0;
      dout_r <= DCMA_DATA_RST;
      doe_r  <= 1'b0;
      hit_r  <= 1'b0;
      wa_r   <= DCMA_ADDR_RST;
    end else begin
      st_r   <= st_nxt;
      wcnt_r <= wcnt_nxt;
      dout_r <= dout_nxt;
      doe_r  <= doe_nxt;
      hit_r  <= hit_nxt;
      wa_r   <= wa_nxt;
    end
  end

  // Memory write on entry to done, one byte per enabled lane after the shift
  always_ff @(posedge I_CORE_CLK) begin
    if (st_r == ST_WAIT && st_nxt == ST_DONE && wr) begin
      for (int b = 0; b < 4; b++) begin
        if (!be_sh[b]) begin
          mem[widx[5:0]][b*8 +: 8] <= wd_sh[b*8 +: 8];
        end
      end
    end
  end

  // Timer input: three-flop sync, change counted when last two agree
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      tin_sync_r <= 3'b000;
      tin_lvl_r  <= 1'b0;
    end else begin
      tin_sync_r <= {tin_sync_r[1:0], I_TMR_IN};
      if (tin_sync_r[2] == tin_sync_r[1]) begin
        tin_lvl_r <= tin_sync_r[2];
      end
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      O_TMR_EVENT <= 1'b0;
    end else begin
      O_TMR_EVENT <= (tin_sync_r[2] == tin_sync_r[1]) && (tin_sync_r[2] != tin_lvl_r);
    end
  end

  assign O_TMR_GPI     = tin_lvl_r;
  assign O_HIT         = hit_r;
  assign O_WADDR       = wa_r;
  assign bus.ready     = !(hit && st_r != ST_DONE);
  assign bus.card_doe  = doe_r && rd;
  assign bus.card_dout = dout_r;
endmodule
`default_nettype wire

/* File: rtl/dcma_mboard.sv */
// Motherboard end: memory controller issuing strobed accesses and a timer output
`timescale 1ns/1ps
`default_nettype none
module dcma_mboard
  import dcma_pkg::*;
(
  input  wire logic              I_CORE_CLK,  // Core clock
  input  wire logic              I_RST_N,     // Sync reset, active low
  input  wire dcma_pkg::dcma_prof_t I_PROFILE,// Static board profile
  input  wire logic              I_REQ,       // Access request
  input  wire logic              I_WR,        // 1 write, 0 read
  input  wire logic [1:0]        I_SEL,       // Select index / space
  input  wire logic              I_WIDE,      // Profile C 32-bit data access
  input  wire logic [19:0]       I_ADDR,      // Word address
  input  wire logic [3:0]        I_BE_N,      // Byte enables, active low
  input  wire logic [31:0]       I_WDATA,     // Write data
  input  wire logic [7:0]        I_TMR_PERIOD,// Timer 0 reload
  output logic                   O_BUSY,      // Access in progress
  output logic                   O_DONE,      // One-cycle completion pulse
  output logic [31:0]            O_RDATA,     // Read data
  output logic                   O_TMR_OUT,   // Timer output pulse on underflow
  dcma_if.motherboard            bus          // Memory port
);
  import dcma_pkg::*;

  typedef enum logic [1:0] {
    MS_IDLE = 2'b00,
    MS_STRB = 2'b01,
    MS_END  = 2'b11
  } dcma_mst_t;

  dcma_mst_t   st_r, st_nxt;
  logic        wr_r, wr_nxt;
  logic [1:0]  sel_r, sel_nxt;
  logic        wide_r, wide_nxt;
  logic [19:0] a_r, a_nxt;
  logic [3:0]  be_r, be_nxt;
  logic [31:0] wd_r, wd_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic        done_nxt;
  logic [7:0]  tcnt_r;
  logic        act;

  always_comb begin
    st_nxt   = st_r;
    wr_nxt   = wr_r;
    sel_nxt  = sel_r;
    wide_nxt = wide_r;
    a_nxt    = a_r;
    be_nxt   = be_r;
    wd_nxt   = wd_r;
    rd_nxt   = rd_r;
    done_nxt = 1'b0;
    case (st_r)
      MS_IDLE: begin
        if (I_REQ) begin
          st_nxt   = MS_STRB;
          wr_nxt   = I_WR;
          sel_nxt  = I_SEL;
          wide_nxt = I_WIDE && (I_PROFILE == DCMA_PROF_C) && (I_SEL == DCMA_SP_DATA);
          a_nxt    = I_ADDR;
          be_nxt   = (I_PROFILE == DCMA_PROF_D) ? ~DCMA_BE_ALL : I_BE_N;
          wd_nxt   = I_WDATA;
        end
      end
      MS_STRB: begin
        // Ready is card logic on this same clock; a synchroniser would show a
        // stale high at the start of every strobe and end it early
        if (bus.ready) begin
          st_nxt   = MS_END;
          rd_nxt   = bus.data;
          done_nxt = 1'b1;
        end
      end
      MS_END: st_nxt = MS_IDLE;
      default: st_nxt = MS_IDLE;
    endcase
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      st_r   <= MS_IDLE;
      wr_r   <= 1'b0;
      sel_r  <= 2'd0;
      wide_r <= 1'b0;
      a_r    <= DCMA_ADDR_RST;
      be_r   <= DCMA_BE_ALL;
      wd_r   <= DCMA_DATA_RST;
      rd_r   <= DCMA_DATA_RST;
      O_DONE <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      wr_r   <= wr_nxt;
      sel_r  <= sel_nxt;
      wide_r <= wide_nxt;
      a_r    <= a_nxt;
      be_r   <= be_nxt;
      wd_r   <= wd_nxt;
      rd_r   <= rd_nxt;
      O_DONE <= done_nxt;
    end
  end

  // Timer 0 down-counter; output pulses one cycle on underflow
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      tcnt_r    <= 8'(DCMA_TMR_DIV_RST);
      O_TMR_OUT <= 1'b0;
    end else begin
      O_TMR_OUT <= (tcnt_r == 8'd0);
      tcnt_r    <= (tcnt_r == 8'd0) ? I_TMR_PERIOD : tcnt_r - 8'd1;
    end
  end

  assign act          = (st_r == MS_STRB);
  assign O_BUSY       = (st_r != MS_IDLE);
  assign O_RDATA      = rd_r;
  assign bus.addr     = a_r;
  assign bus.half_hi  = (act && wide_r) ? 2'b01 : 2'b00;
  assign bus.be_n     = be_r;
  assign bus.sel_n    = act ? ~(4'b0001 << sel_r) : 4'hF;
  assign bus.oe_n     = !(act && !wr_r);
  assign bus.re_n     = !(act && !wr_r);
  assign bus.we_n     = !(act && wr_r);
  assign bus.iostrb_n = !(act && I_PROFILE == DCMA_PROF_C && sel_r == DCMA_SP_IO);
  assign bus.mstrb_n  = !(act && I_PROFILE == DCMA_PROF_C && sel_r != DCMA_SP_IO);
  assign bus.mb_dout  = wd_r;
  assign bus.mb_doe   = act && wr_r;
endmodule
`default_nettype wire

/* File: tb/dcma_chk.sv */
// Checker: pin-level relations on the memory port between the two ends
`timescale 1ns/1ps
`default_nettype none
module dcma_chk (
  input wire logic       I_CORE_CLK, // Core clock
  input wire logic       I_RST_N,    // Sync reset, low
  input wire logic [1:0] half_hi,    // Upper half bits
  input wire logic [3:0] sel_n,      // Selects, low
  input wire logic       re_n,       // Read enable
  input wire logic       we_n,       // Write enable
  input wire logic       iostrb_n,   // I/O strobe
  input wire logic       mstrb_n,    // Memory strobe
  input wire logic       ready,      // Card ready
  input wire logic       mb_doe,     // Motherboard drives data
  input wire logic       card_doe    // Card drives data
);
  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (!I_RST_N);
  // Wait is bounded so a stuck-low ready shows up as a failure
  sequence s_wait; !ready ##1 !ready ##[1:4] ready; endsequence
  sequence s_held; !re_n; endsequence
  property p_one_sel; $onehot0(~sel_n); endproperty
  a_one_sel: assert property (p_one_sel) else $error("two selects low");
  property p_rw; !re_n |-> we_n; endproperty
  a_rw: assert property (p_rw) else $error("read and write strobes together");
  property p_wait; $fell(ready) |-> s_wait; endproperty
  a_wait: assert property (p_wait) else $error("ready wait out of bounds");
  property p_hold; (!re_n && !ready) |=> s_held; endproperty
  a_hold: assert property (p_hold) else $error("read strobe left before ready");
  property p_fight; card_doe |-> !mb_doe && we_n; endproperty
  a_fight: assert property (p_fight) else $error("data driven by both ends");
  property p_mbdrv; mb_doe |-> re_n; endproperty
  a_mbdrv: assert property (p_mbdrv) else $error("write data during read");
  property p_iostrb; !iostrb_n |-> !sel_n[2]; endproperty
  a_iostrb: assert property (p_iostrb) else $error("io strobe outside io space");
  property p_mstrb; !mstrb_n |-> sel_n[2]; endproperty
  a_mstrb: assert property (p_mstrb) else $error("memory strobe in io space");
  property p_half; half_hi != 2'h0 |-> !sel_n[0]; endproperty
  a_half: assert property (p_half) else $error("upper bits outside data space");
  property p_io16; !sel_n[2] |-> half_hi == 2'h0; endproperty
  a_io16: assert property (p_io16) else $error("wide access in io space");
endmodule
`default_nettype wire

/* File: tb/dcma_bench.sv */
// Bench: both ends joined, one scenario per profile (profile B run once per endianness) plus the timer pins
`timescale 1ns/1ps
`default_nettype none
module dcma_bench;
  import dcma_pkg::*;
  logic        clk, rst_n, req, wr, wide, big, tin, tev, tgpi, done, timer_output_pin;
  logic        hit, busy, hit_seen;
  dcma_prof_t  prof;
  logic [1:0]  sel, nar;
  logic [19:0] addr, waddr;
  logic [3:0]  be_n;
  logic [31:0] wdata, rdata;
  logic [7:0]  per;
  int          fails, tests_run, cyc;
  dcma_if bus ();
  dcma_card u_dcma_card (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_PROFILE(prof), .I_BIG_ENDIAN(big),
    .I_NARROW(nar), .I_TMR_IN(tin), .O_TMR_EVENT(tev), .O_TMR_GPI(tgpi), .O_HIT(hit), .O_WADDR(waddr), .bus(bus));
  dcma_mboard u_dcma_mboard (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_PROFILE(prof), .I_REQ(req), .I_WR(wr),
    .I_SEL(sel), .I_WIDE(wide), .I_ADDR(addr), .I_BE_N(be_n), .I_WDATA(wdata), .I_TMR_PERIOD(per),
    .O_BUSY(busy), .O_DONE(done), .O_RDATA(rdata), .O_TMR_OUT(timer_output_pin), .bus(bus));
  dcma_chk u_dcma_chk (.I_CORE_CLK(clk), .I_RST_N(rst_n), .half_hi(bus.half_hi), .sel_n(bus.sel_n),
    .re_n(bus.re_n), .we_n(bus.we_n), .iostrb_n(bus.iostrb_n), .mstrb_n(bus.mstrb_n),
    .ready(bus.ready), .mb_doe(bus.mb_doe), .card_doe(bus.card_doe));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task end_sim;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Ceiling well above the few hundred cycles the scenarios need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      end_sim();
    end
  end
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  // Profile is static, so every change goes through a reset
  task rst_to(input dcma_prof_t p);
    @(posedge clk);
    rst_n <= 1'b0;
    prof  <= p;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
  endtask
  task acc(input logic w, input logic [1:0] s, input logic [19:0] a, input logic [3:0] b,
           input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req <= 1'b1;
    wr <= w;
    sel <= s;
    addr <= a;
    be_n <= b;
    wdata <= d;
    @(posedge clk);
    req <= 1'b0;
    @(negedge clk);
    chk("busy", 32'(busy), 32'h0000_0001);
    do begin
      @(negedge clk);
      n++;
    end while (done !== 1'b1 && n < 60);
    hit_seen = hit;
    chk("done", 32'(done), 32'h0000_0001);
    chk("waddr", 32'(waddr), 32'(a));
    @(posedge clk);
  endtask
  task rchk(input string nm, input logic [1:0] s, input logic [19:0] a, input logic [31:0] m,
            input logic [31:0] e);
    acc(1'b0, s, a, 4'h0, 32'h0000_0000);
    chk(nm, rdata & m, e);
    chk("hit", 32'(hit_seen), 32'(e != 32'h0000_0000));
  endtask
  task t_prof_a;
    rst_to(DCMA_PROF_A);
    acc(1'b1, 2'h0, 20'h0_0003, 4'h0, 32'hA5A5_1234);
    acc(1'b1, 2'h0, 20'hF_0003, 4'h0, 32'h0BAD_0BAD);
    rchk("a_prim", 2'h0, 20'h0_0003, 32'hFFFF_FFFF, 32'hA5A5_1234);
    rchk("a_above", 2'h0, 20'hF_0003, 32'hFFFF_FFFF, 32'h0000_0000);
    acc(1'b1, 2'h2, 20'hF_FFFF, 4'h0, 32'h5A5A_C3C3);
    rchk("a_third", 2'h2, 20'hF_FFFF, 32'hFFFF_FFFF, 32'h5A5A_C3C3);
    nar <= 2'h2;
    rst_to(DCMA_PROF_A);
    rchk("a_rom8", 2'h0, 20'h0_0003, 32'hFFFF_FFFF, 32'h0000_0034);
    nar <= 2'h0;
  endtask
  task t_prof_b(input logic be);
    big <= be;
    nar <= 2'h2;
    rst_to(DCMA_PROF_B);
    acc(1'b1, 2'h1, 20'hF_FFF0, be ? 4'h7 : 4'hE, be ? 32'hC300_0000 : 32'h0000_00C3);
    rchk("b_lane", 2'h1, 20'hF_FFF0, be ? 32'hFF00_0000 : 32'h0000_00FF,
         be ? 32'hC300_0000 : 32'h0000_00C3);
    nar <= 2'h0;
    rst_to(DCMA_PROF_B);
    acc(1'b1, 2'h2, 20'hF_FFF1, 4'h0, 32'h1234_5678);
    rchk("b_word", 2'h2, 20'hF_FFF1, 32'hFFFF_FFFF, 32'h1234_5678);
  endtask
  task t_prof_c;
    rst_to(DCMA_PROF_C);
    acc(1'b1, 2'h1, 20'h7_FFFF, 4'h0, 32'h0000_1111);
    acc(1'b1, 2'h1, 20'h8_0005, 4'h0, 32'h0000_2222);
    rchk("c_plow", 2'h1, 20'h7_FFFF, 32'h0000_FFFF, 32'h0000_0000);
    rchk("c_prog", 2'h1, 20'h8_0005, 32'h0000_FFFF, 32'h0000_2222);
    acc(1'b1, 2'h2, 20'hF_FFFE, 4'h0, 32'h0000_3333);
    rchk("c_io", 2'h2, 20'hF_FFFE, 32'h0000_FFFF, 32'h0000_3333);
    wide <= 1'b1;
    acc(1'b1, 2'h0, 20'hF_0007, 4'h0, 32'hDEAD_BEEF);
    rchk("c_wide", 2'h0, 20'hF_0007, 32'hFFFF_FFFF, 32'hDEAD_BEEF);
    wide <= 1'b0;
  endtask
  task t_prof_d;
    rst_to(DCMA_PROF_D);
    acc(1'b1, 2'h3, 20'h0_000F, 4'h0, 32'h1357_9BDF);
    acc(1'b1, 2'h3, 20'h0_0010, 4'h0, 32'hFFFF_0000);
    rchk("d_top", 2'h3, 20'h0_000F, 32'hFFFF_FFFF, 32'h1357_9BDF);
    rchk("d_over", 2'h3, 20'h0_0010, 32'hFFFF_FFFF, 32'h0000_0000);
  endtask
  task t_timer;
    int n;
    n = 0;
    // Reload 3 gives one underflow every four cycles, edges of the window may add one
    repeat (40) begin
      @(negedge clk);
      if (timer_output_pin === 1'b1) n++;
    end
    chk("tmr_out", 32'(n >= 9 && n <= 11), 32'h0000_0001);
    @(posedge clk);
    tin <= 1'b1;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (tev !== 1'b1 && n < 8);
    chk("tmr_evt", 32'(tev), 32'h0000_0001);
    repeat (2) @(negedge clk);
    chk("tmr_gpi", 32'(tgpi), 32'h0000_0001);
  endtask
  initial begin
    rst_n = 1'b0;
    prof = DCMA_PROF_A;
    {req, wr, wide, big, tin, sel, nar, addr, wdata} = '0;
    be_n = 4'hF;
    per = 8'h03;
    repeat (12) @(posedge clk);
    t_prof_a();
    t_prof_b(1'b0);
    t_prof_b(1'b1);
    t_prof_c();
    t_timer();
    t_prof_d();
    end_sim();
  end
endmodule
`default_nettype wire
